// file: src/ivm_params.svh
// Constants for the interrupt vector map: vector addresses, watchdog codes
// and the vector-change window. Included by the package and the design.
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH

`define IVM_VEC_RESET       16'h0000
`define IVM_VEC_EXT0        16'h0002
`define IVM_VEC_EXT1        16'h0004
`define IVM_VEC_EXT2        16'h0006
`define IVM_VEC_EXT3        16'h0008
`define IVM_VEC_EXT4        16'h000A
`define IVM_VEC_EXT5        16'h000C
`define IVM_VEC_EXT6        16'h000E
`define IVM_VEC_EXT7        16'h0010
`define IVM_VEC_PCI0        16'h0012
`define IVM_VEC_PCI1        16'h0014
`define IVM_VEC_USB_GEN     16'h0016
`define IVM_VEC_USB_EP      16'h0018
`define IVM_VEC_WDOG        16'h001A
`define IVM_VEC_T1_CAPT     16'h001C
`define IVM_VEC_T1_COMPA    16'h001E
`define IVM_VEC_T1_COMPB    16'h0020
`define IVM_VEC_T1_COMPC    16'h0022
`define IVM_VEC_T1_OVF      16'h0024
`define IVM_VEC_T0_COMPA    16'h0026
`define IVM_VEC_T0_COMPB    16'h0028
`define IVM_VEC_T0_OVF      16'h002A
`define IVM_VEC_SPI         16'h002C
`define IVM_VEC_SER_RX      16'h002E
`define IVM_VEC_SER_TXEMPTY 16'h0030
`define IVM_VEC_SER_TX      16'h0032
`define IVM_VEC_ACOMP       16'h0034
`define IVM_VEC_NVM_RDY     16'h0036
`define IVM_VEC_STORE_RDY   16'h0038
`define IVM_VEC_STEP        16'h0002

`define IVM_WDOG_DIV7       15
`define IVM_WDOG_BASE_CYC   2048
`define IVM_WDOG_MAX_CODE   4'h9
`define IVM_CHG_WINDOW      4

`endif

// file: src/ivm_pkg.sv
// Types shared by the interrupt vector map.
// Assumes the params header is on the include path.
`include "ivm_params.svh"
package ivm_pkg;
  localparam int IVM_NSRC = 28;
  typedef logic [15:0] ivm_addr_t;
  typedef enum logic [1:0] {IVM_IDLE, IVM_OPEN} ivm_chg_t;
endpackage : ivm_pkg

// file: src/ivm_vector_map.sv
// Vector map: requests to program addresses, vector-select sequence,
// and the watchdog time-out counter for prescale codes 0 to 9 at WDOG_DIV from 1 to 16.
// Assumes requests are synchronous to ref_clk and held until taken.
`timescale 1ns/1ps
`include "ivm_params.svh"
module ivm_vector_map
  import ivm_pkg::*;
#(
  parameter int        WDOG_DIV     = `IVM_WDOG_DIV7,
  parameter ivm_addr_t BOOT_START   = 16'h3800
) (
  // Clock and reset
  input  wire  logic              ref_clk,
  input  wire  logic              rst_b,
  // Reset causes
  input  wire  logic [5:0]        reset_cause,
  // Interrupt requests, bit i is vector i+2
  input  wire  logic [27:0]       irq_req,
  // Vector control bits written by the core
  input  wire  logic              ctl_wr,
  input  wire  logic              vector_select_wr,
  input  wire  logic              vector_change_enable_wr,
  // Watchdog control
  input  wire  logic              wdog_run,
  input  wire  logic              wdog_kick,
  input  wire  logic [3:0]        wdog_prescale,
  // Outputs to the core
  output logic                    vec_valid,
  output ivm_addr_t               vec_addr,
  output logic                    vector_select,
  output logic                    vector_change_enable,
  output logic                    irq_hold,
  output logic                    wdog_early,
  output logic                    wdog_timeout,
  output logic                    wdog_code_bad
);

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  // Base addresses, index i is request bit i
  localparam ivm_addr_t VEC_BASE [IVM_NSRC] = '{
    // External requests
    `IVM_VEC_EXT0,
    `IVM_VEC_EXT1,
    `IVM_VEC_EXT2,
    `IVM_VEC_EXT3,
    `IVM_VEC_EXT4,
    `IVM_VEC_EXT5,
    `IVM_VEC_EXT6,
    `IVM_VEC_EXT7,
    // Pin change
    `IVM_VEC_PCI0,
    `IVM_VEC_PCI1,
    // USB and watchdog
    `IVM_VEC_USB_GEN,
    `IVM_VEC_USB_EP,
    `IVM_VEC_WDOG,
    // 16-bit timer
    `IVM_VEC_T1_CAPT,
    `IVM_VEC_T1_COMPA,
    `IVM_VEC_T1_COMPB,
    `IVM_VEC_T1_COMPC,
    `IVM_VEC_T1_OVF,
    // 8-bit timer
    `IVM_VEC_T0_COMPA,
    `IVM_VEC_T0_COMPB,
    `IVM_VEC_T0_OVF,
    // Serial
    `IVM_VEC_SPI,
    `IVM_VEC_SER_RX,
    `IVM_VEC_SER_TXEMPTY,
    `IVM_VEC_SER_TX,
    // Analog and memory
    `IVM_VEC_ACOMP,
    `IVM_VEC_NVM_RDY,
    `IVM_VEC_STORE_RDY
  };

  // ----------------------------------------------------------------
  // Per-entry offset and priority
  // ----------------------------------------------------------------
  // Lowest pending bit wins; the offset applies to all but reset
  ivm_addr_t           vec_tab [IVM_NSRC];
  ivm_addr_t           boot_ofs;
  logic [IVM_NSRC:0]   lower_pend;
  logic [IVM_NSRC-1:0] grant;

  assign lower_pend[0] = 1'b0;
  for (genvar i = 0; i < IVM_NSRC; i++) begin : g_tab
    assign vec_tab[i]      = VEC_BASE[i] + boot_ofs;
    assign grant[i]        = irq_req[i] && !lower_pend[i];
    assign lower_pend[i+1] = lower_pend[i] | irq_req[i];
  end

  // ----------------------------------------------------------------
  // Vector-select change sequence
  // ----------------------------------------------------------------
  // Select changes only inside the window opened by change enable
  ivm_chg_t   chg_st_q, chg_st_d;
  logic [2:0] chg_cnt_q, chg_cnt_d;
  logic       sel_q, sel_d;
  logic       hold_q, hold_d;
  logic       open_q, open_d;

  always_comb begin
    chg_st_d  = chg_st_q;
    chg_cnt_d = chg_cnt_q;
    sel_d     = sel_q;
    hold_d    = 1'b0;
    case (chg_st_q)
      IVM_IDLE: begin
        if (ctl_wr && vector_change_enable_wr) begin
          chg_st_d  = IVM_OPEN;
          chg_cnt_d = 3'(`IVM_CHG_WINDOW - 1);
          hold_d    = 1'b1;
        end
      end
      IVM_OPEN: begin
        hold_d = 1'b1;
        if (ctl_wr && !vector_change_enable_wr) begin
          sel_d    = vector_select_wr;
          chg_st_d = IVM_IDLE;
        end else if (chg_cnt_q == 3'h0) begin
          chg_st_d = IVM_IDLE;
          hold_d   = 1'b0;
        end else begin
          chg_cnt_d = chg_cnt_q - 3'h1;
        end
      end
      default: chg_st_d = IVM_IDLE;
    endcase
    open_d = (chg_st_d == IVM_OPEN);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      chg_st_q  <= IVM_IDLE;
      chg_cnt_q <= 3'h0;
      sel_q     <= 1'b0;
      hold_q    <= 1'b0;
      open_q    <= 1'b0;
    end else begin
      chg_st_q  <= chg_st_d;
      chg_cnt_q <= chg_cnt_d;
      sel_q     <= sel_d;
      hold_q    <= hold_d;
      open_q    <= open_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog count-clock divider
  // ----------------------------------------------------------------
  // One-cycle count enable every WDOG_DIV clocks
  logic [3:0] div_q, div_d;
  logic       tick_q, tick_d;

  always_comb begin
    div_d  = div_q;
    tick_d = 1'b0;
    if (!wdog_run || wdog_kick) begin
      div_d = 4'h0;
    end else if (div_q == 4'(WDOG_DIV - 1)) begin
      div_d  = 4'h0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Prescale decode
  // ----------------------------------------------------------------
  // Registered limit keeps the shifter out of the counter path
  logic [21:0] lim_q, lim_d;
  logic        bad_q, bad_d;

  always_comb begin
    bad_d = (wdog_prescale > `IVM_WDOG_MAX_CODE);
    lim_d = 22'(`IVM_WDOG_BASE_CYC) << wdog_prescale;
    if (bad_d) begin
      lim_d = lim_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lim_q <= 22'(`IVM_WDOG_BASE_CYC);
      bad_q <= 1'b0;
    end else begin
      lim_q <= lim_d;
      bad_q <= bad_d;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------
  // Early warning at the limit, time-out at twice it
  logic [21:0] wcnt_q, wcnt_d;
  logic        early_q, early_d;
  logic        tout_q, tout_d;

  always_comb begin
    wcnt_d  = wcnt_q;
    early_d = 1'b0;
    tout_d  = 1'b0;
    if (!wdog_run || wdog_kick || bad_q) begin
      wcnt_d = 22'h0;
    end else if (tick_q) begin
      wcnt_d  = wcnt_q + 22'h1;
      early_d = (wcnt_d == lim_q);
      if (wcnt_d == (lim_q << 1)) begin
        tout_d = 1'b1;
        wcnt_d = 22'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wcnt_q  <= 22'h0;
      early_q <= 1'b0;
      tout_q  <= 1'b0;
    end else begin
      wcnt_q  <= wcnt_d;
      early_q <= early_d;
      tout_q  <= tout_d;
    end
  end

  // ----------------------------------------------------------------
  // Vector selection
  // ----------------------------------------------------------------
  // Reset causes beat requests; requests wait while held
  logic      vv_q, vv_d;
  ivm_addr_t va_q, va_d;

  assign boot_ofs = sel_q ? BOOT_START : 16'h0000;

  always_comb begin
    vv_d = 1'b0;
    va_d = va_q;
    if (|reset_cause) begin
      vv_d = 1'b1;
      va_d = `IVM_VEC_RESET;
    end else if (!hold_q && (|irq_req)) begin
      vv_d = 1'b1;
      for (int k = 0; k < IVM_NSRC; k++) begin
        if (grant[k]) begin
          va_d = vec_tab[k];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      vv_q <= 1'b0;
      va_q <= 16'h0000;
    end else begin
      vv_q <= vv_d;
      va_q <= va_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop
  assign vec_valid            = vv_q;
  assign vec_addr             = va_q;
  assign vector_select        = sel_q;
  assign vector_change_enable = open_q;
  assign irq_hold             = hold_q;
  assign wdog_early           = early_q;
  assign wdog_timeout         = tout_q;
  assign wdog_code_bad        = bad_q;

endmodule : ivm_vector_map

// file: verification/ivm_vector_map_properties.sv
// Port checker for the vector map.
// Bound to every ivm_vector_map instance; one clock, sync reset.
`timescale 1ns/1ps
module ivm_chk
  import ivm_pkg::*;
(
  // Map inputs
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [5:0]  reset_cause,
  input wire logic [27:0] irq_req,
  input wire logic        ctl_wr,
  input wire logic        vector_select_wr,
  input wire logic        vector_change_enable_wr,
  input wire logic [3:0]  wdog_prescale,
  // Map outputs
  input wire logic        vec_valid,
  input wire ivm_addr_t   vec_addr,
  input wire logic        vector_select,
  input wire logic        vector_change_enable,
  input wire logic        irq_hold,
  input wire logic        wdog_code_bad
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire quiet = !(|reset_cause) && !irq_hold && !vector_select && !ctl_wr;
  rst_vec_a: assert property (
    |reset_cause |=> vec_valid && vec_addr == 16'h0000) else $error("rst");
  ext_vec_a: assert property (
    quiet && irq_req[0] |=> vec_addr == 16'h0002) else $error("ext");
  hold_blk_a: assert property (
    irq_hold && !(|reset_cause) |=> !vec_valid) else $error("hold");
  chg_open_a: assert property (
    ctl_wr && vector_change_enable_wr && !vector_change_enable
    |=> vector_change_enable && irq_hold) else $error("open");
  chg_close_a: assert property (
    $rose(vector_change_enable) |-> ##[1:4] !vector_change_enable)
    else $error("close");
  sel_set_a: assert property (
    vector_change_enable && ctl_wr && !vector_change_enable_wr
    |=> vector_select == $past(vector_select_wr)) else $error("sel");
  sel_keep_a: assert property (
    !vector_change_enable |=> $stable(vector_select)) else $error("keep");
  code_bad_a: assert property (
    1'b1 |=> wdog_code_bad == ($past(wdog_prescale) > 4'h9))
    else $error("code");
  cover property (vec_valid && vec_addr == 16'h0000);
  cover property ($rose(vector_select));
  cover property ($rose(wdog_code_bad));
endmodule : ivm_chk
bind ivm_vector_map ivm_chk ivm_chk_i (.*);

// file: verification/ivm_core_model.sv
// Core-side model: writes the control byte, logs fetched vectors.
// Shares ref_clk with the vector map.
`timescale 1ns/1ps
module ivm_core_model
  import ivm_pkg::*;
(
  // Clock and fetch
  input  wire logic      ref_clk,
  input  wire logic      vec_valid,
  input  wire ivm_addr_t vec_addr,
  // Control byte and fetch log
  output logic           ctl_wr = 0,
  output logic           vector_select_wr = 0,
  output logic           vector_change_enable_wr = 0,
  output ivm_addr_t      fetch_addr
);
  always @(posedge ref_clk) if (vec_valid) fetch_addr <= vec_addr;
  task write_ctl(input logic ce, input logic sel);
    ctl_wr = 1;
    vector_change_enable_wr = ce;
    vector_select_wr = sel;
    @(posedge ref_clk);
    #1;
  endtask : write_ctl
  task idle;
    ctl_wr = 0;
  endtask : idle
endmodule : ivm_core_model

// file: verification/ivm_vector_map_test.sv
// Self-checking bench for the vector map.
// Checker is bound in; core model drives the control byte.
`timescale 1ns/1ps
module ivm_vector_map_test;
  import ivm_pkg::*;
  localparam ivm_addr_t BOOT = 16'h3800;
  localparam int        DIV  = 2;
  logic ref_clk = 0, rst_b = 0, wdog_run = 0, wdog_kick = 0;
  logic [5:0] reset_cause = 0;
  logic [27:0] irq_req = 0;
  logic [3:0] wdog_prescale = 0;
  logic ctl_wr, vector_select_wr, vector_change_enable_wr, vec_valid;
  logic vector_select, vector_change_enable, irq_hold;
  logic wdog_early, wdog_timeout, wdog_code_bad;
  ivm_addr_t vec_addr, fetch_addr;
  int num_errors = 0, tests_run = 0;
  always #2.5 ref_clk = ~ref_clk;
  ivm_vector_map #(.WDOG_DIV(DIV), .BOOT_START(BOOT)) ivm_vector_map_i (.*);
  ivm_core_model ivm_core_model_i (.*);
  task step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task close_out;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task test_reset;
    for (int i = 0; i < 6; i++) begin
      reset_cause = 6'h01 << i;
      irq_req = 28'h1;
      step;
      check("rst", {vec_valid, vec_addr}, 17'h10000);
      reset_cause = 0;
      irq_req = 0;
      step;
    end
    check("fetch", fetch_addr, 0);
    $display("reset done");
  endtask : test_reset
  task test_table(ivm_addr_t base);
    for (int i = 0; i < 28; i++) begin
      irq_req = 28'hFFFFFFF << i;
      step;
      check("vec", vec_addr, base + 2 * i);
      irq_req = 0;
      step;
    end
    $display("table done");
  endtask : test_table
  task test_vsel(logic sel);
    ivm_core_model_i.write_ctl(1, 0);
    irq_req = 28'h1;
    check("open", {vector_change_enable, irq_hold}, 2'b11);
    ivm_core_model_i.write_ctl(0, sel);
    ivm_core_model_i.idle;
    check("sel", {vec_valid, vector_select}, {1'b0, sel});
    step(2);
    check("hold", irq_hold, 0);
    check("go", {vec_valid, vec_addr}, {1'b1, BOOT * sel + 16'h2});
    irq_req = 0;
    ivm_core_model_i.write_ctl(1, 0);
    ivm_core_model_i.idle;
    step(5);
    check("shut", {vector_change_enable, vector_select}, sel);
    $display("select done");
  endtask : test_vsel
  task test_wdog;
    int n, e;
    for (int c = 10; c < 16; c++) begin
      wdog_prescale = 4'(c);
      step(2);
      check("bad", wdog_code_bad, 1);
    end
    for (int c = 0; c < 2; c++) begin
      wdog_prescale = 4'(c);
      wdog_run = 1;
      wdog_kick = 1;
      e = (2048 << c) * DIV;
      n = 0;
      step;
      wdog_kick = 0;
      while (wdog_early !== 1 && n < 40000) begin
        step;
        n++;
      end
      check("early", n >= e - 3 && n <= e + 3, 1);
      while (wdog_timeout !== 1 && n < 40000) begin
        step;
        n++;
      end
      check("tmo", n >= 2 * e - 3 && n <= 2 * e + 3, 1);
    end
    wdog_run = 0;
    $display("watchdog done");
  endtask : test_wdog
  initial begin
    step(20);
    rst_b = 1;
    test_reset;
    test_table(16'h0002);
    test_vsel(1);
    test_table(BOOT + 16'h0002);
    test_reset;
    test_vsel(0);
    test_wdog;
    close_out;
  end
  initial begin
    #(5 * 60000);
    num_errors++;
    close_out;
  end
endmodule : ivm_vector_map_test
